// ===== logic/sciw_pkg.sv
package sciw_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] IEN_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] DATA_OFS = 4'hC;
  // control register bit positions
  localparam int WAKE_BIT = 0;
  localparam int LEN9_BIT = 1;
  localparam int ILT_BIT = 2;
  localparam int IDLE_ON_WAKEUP_ENABLE_BIT = 3;
  localparam int ASLEEP_BIT = 4;
  localparam int CTRL_W = 5;
  // flag positions, shared by status and enable registers
  localparam int F_TRANSMIT_EMPTY_FLAG = 0;
  localparam int F_TC = 1;
  localparam int F_RECEIVE_FULL_FLAG = 2;
  localparam int F_IDLE = 3;
  localparam int F_EDGE = 4;
  localparam int F_BRK = 5;
  localparam int F_OR = 6;
  localparam int F_NF = 7;
  localparam int F_FE = 8;
  localparam int F_PF = 9;
  localparam int NFLAG = 10;
  localparam logic [9:0] W1C_MASK = 10'h3FC;
  localparam logic [9:0] TX_GRP = 10'h003;
  localparam logic [9:0] RX_GRP = 10'h03C;
  localparam logic [9:0] ERR_GRP = 10'h3C0;
  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [9:0] IEN_RST = 10'h000;
  // idle character length in bit times, start and stop included
  localparam logic [3:0] IDLE_BITS_8 = 4'hA;
  localparam logic [3:0] IDLE_BITS_9 = 4'hB;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== logic/sciw_idle_det.sv
`timescale 1ns/1ps
module sciw_idle_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // receiver timing
  input wire logic bit_tick_i,
  input wire logic rxd_i,
  input wire logic start_done_i,
  input wire logic stop_done_i,
  // configuration
  input wire logic ilt_i,
  input wire logic len9_i,
  // one pulse per idle period
  output logic idle_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic armed;
    logic idle;
  } sciw_idle_s;

  sciw_idle_s q;
  sciw_idle_s nxt;
  logic [3:0] limit;

  always_comb begin
    nxt = q;
    nxt.idle = 1'b0;
    limit = len9_i ? sciw_pkg::IDLE_BITS_9 : sciw_pkg::IDLE_BITS_8;
    // start point of the count follows the idle type select
    if ((!ilt_i && start_done_i) || (ilt_i && stop_done_i)) begin
      nxt.armed = 1'b1;
      nxt.cnt = 4'h0;
    end else if (bit_tick_i && q.armed) begin
      if (!rxd_i) begin
        nxt.cnt = 4'h0;
      end else if (q.cnt + 4'h1 == limit) begin
        // disarm so a long idle gap raises only one pulse
        nxt.idle = 1'b1;
        nxt.armed = 1'b0;
        nxt.cnt = 4'h0;
      end else begin
        nxt.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{cnt: 4'h0, armed: 1'b1, idle: 1'b0};
    end else begin
      q <= nxt;
    end
  end

  assign idle_o = q.idle;
endmodule

// ===== logic/sciw_top.sv
`timescale 1ns/1ps
// Summary of operation
// - receiver leaves sleep by itself at message end or next message start
// - wake select 0: a full idle character clears receiver_asleep
// - idle character is 10 bit times, 11 with 9-bit data
// - asleep with idle_on_wakeup_enable 0: waking idle leaves idle flag clear
// - after idle wakeup the next character sets receive_full_flag
// - idle_on_wakeup_enable 1: every idle sets idle flag, asleep or not
// - idle_type_select 0: idle count starts after the start bit
// - idle_type_select 1: idle count starts after the stop bit
// - wake select 1: character with top bit one clears receiver_asleep
// - address character is kept and sets receive_full_flag
// - three requests: transmit, receive, error groups
// - ten flags each masked by own enable; flags still poll
// - transmit_empty_flag with its enable keeps requesting
// - transmit_complete_flag when transmitter idle; with enable requests
module sciw_top (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // axi4-lite write address and data
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // receiver frame engine
  input wire logic RX_LINE_I,
  input wire logic RX_BIT_TICK_I,
  input wire logic RX_START_DONE_I,
  input wire logic RX_STOP_DONE_I,
  input wire logic RX_MSB_VALID_I,
  input wire logic RX_MSB_I,
  input wire logic RX_CHAR_DONE_I,
  input wire logic [8:0] RX_CHAR_I,
  input wire logic RX_EDGE_I,
  input wire logic RX_BREAK_I,
  input wire logic RX_NOISE_I,
  input wire logic RX_FRAMING_I,
  input wire logic RX_PARITY_I,
  // transmitter state
  input wire logic TX_BUF_FREE_I,
  input wire logic TX_IDLE_I,
  // configuration to the frame engine
  output logic RX_LEN9_O,
  output logic RX_ASLEEP_O,
  // interrupt requests
  output logic IRQ_TX_O,
  output logic IRQ_RX_O,
  output logic IRQ_ERR_O,
  output logic IRQ_O
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [3:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [4:0] ctrl;
    logic [9:0] ien;
    logic [9:0] flags;
    logic [8:0] data;
    logic irq_tx;
    logic irq_rx;
    logic irq_err;
    logic irq;
  } sciw_top_s;

  sciw_top_s q;
  sciw_top_s nxt;
  logic idle_pulse;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [9:0] fset;
  logic [9:0] fclr;
  logic w_fire;

  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a == sciw_pkg::CTRL_OFS) || (a == sciw_pkg::IEN_OFS) ||
                (a == sciw_pkg::STAT_OFS) || (a == sciw_pkg::DATA_OFS);
  endfunction

  sciw_idle_det u_idle (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESETN_I),
    .bit_tick_i(RX_BIT_TICK_I),
    .rxd_i(RX_LINE_I),
    .start_done_i(RX_START_DONE_I),
    .stop_done_i(RX_STOP_DONE_I),
    .ilt_i(q.ctrl[sciw_pkg::ILT_BIT]),
    .len9_i(q.ctrl[sciw_pkg::LEN9_BIT]),
    .idle_o(idle_pulse)
  );

  always_comb begin
    nxt = q;
    fset = '0;
    fclr = '0;
    wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    wd = q.wdata & wmask;
    w_fire = q.aw_have && q.w_have && !q.bvalid;

    // address and data are latched separately, in either order
    if (S_AXI_AWVALID_I && q.awready) begin
      nxt.aw_have = 1'b1;
      nxt.aw_addr = {S_AXI_AWADDR_I[3:2], 2'b00};
    end
    if (S_AXI_WVALID_I && q.wready) begin
      nxt.w_have = 1'b1;
      nxt.wdata = S_AXI_WDATA_I;
      nxt.wstrb = S_AXI_WSTRB_I;
    end
    if (q.bvalid && S_AXI_BREADY_I) begin
      nxt.bvalid = 1'b0;
    end
    if (w_fire) begin
      nxt.aw_have = 1'b0;
      nxt.w_have = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = is_mapped(q.aw_addr) ? sciw_pkg::RESP_OKAY : sciw_pkg::RESP_SLVERR;
      case (q.aw_addr)
        sciw_pkg::CTRL_OFS: begin
          nxt.ctrl = (q.ctrl & ~wmask[4:0]) | wd[4:0];
        end
        sciw_pkg::IEN_OFS: begin
          nxt.ien = (q.ien & ~wmask[9:0]) | wd[9:0];
        end
        sciw_pkg::STAT_OFS: begin
          fclr = wd[9:0] & sciw_pkg::W1C_MASK;
        end
        default: begin
        end
      endcase
    end
    nxt.awready = !nxt.aw_have;
    nxt.wready = !nxt.w_have;

    if (q.rvalid && S_AXI_RREADY_I) begin
      nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && q.arready) begin
      nxt.rvalid = 1'b1;
      nxt.rresp = is_mapped({S_AXI_ARADDR_I[3:2], 2'b00}) ?
                  sciw_pkg::RESP_OKAY : sciw_pkg::RESP_SLVERR;
      case ({S_AXI_ARADDR_I[3:2], 2'b00})
        sciw_pkg::CTRL_OFS: nxt.rdata = {27'h0000000, q.ctrl};
        sciw_pkg::IEN_OFS: nxt.rdata = {22'h000000, q.ien};
        sciw_pkg::STAT_OFS: nxt.rdata = {22'h000000, q.flags};
        sciw_pkg::DATA_OFS: nxt.rdata = {23'h000000, q.data};
        default: nxt.rdata = 32'h00000000;
      endcase
    end
    nxt.arready = !nxt.rvalid;

    // idle period: wakes an idle-line sleeper, flag per idle_on_wakeup_enable
    if (idle_pulse) begin
      if (q.ctrl[sciw_pkg::ASLEEP_BIT] && !q.ctrl[sciw_pkg::WAKE_BIT]) begin
        nxt.ctrl[sciw_pkg::ASLEEP_BIT] = 1'b0;
      end
      if (!q.ctrl[sciw_pkg::ASLEEP_BIT] || q.ctrl[sciw_pkg::IDLE_ON_WAKEUP_ENABLE_BIT]) begin
        fset[sciw_pkg::F_IDLE] = 1'b1;
      end
    end
    // top bit arrives before the stop bit, so the char below is kept
    if (RX_MSB_VALID_I && RX_MSB_I && q.ctrl[sciw_pkg::WAKE_BIT]) begin
      nxt.ctrl[sciw_pkg::ASLEEP_BIT] = 1'b0;
    end
    // a sleeping receiver drops the char; a full buffer is not overwritten
    if (RX_CHAR_DONE_I && !q.ctrl[sciw_pkg::ASLEEP_BIT]) begin
      if (q.flags[sciw_pkg::F_RECEIVE_FULL_FLAG] && !fclr[sciw_pkg::F_RECEIVE_FULL_FLAG]) begin
        fset[sciw_pkg::F_OR] = 1'b1;
      end else begin
        nxt.data = RX_CHAR_I;
        fset[sciw_pkg::F_RECEIVE_FULL_FLAG] = 1'b1;
      end
    end
    fset[sciw_pkg::F_EDGE] = fset[sciw_pkg::F_EDGE] | RX_EDGE_I;
    fset[sciw_pkg::F_BRK] = fset[sciw_pkg::F_BRK] | RX_BREAK_I;
    fset[sciw_pkg::F_NF] = fset[sciw_pkg::F_NF] | RX_NOISE_I;
    fset[sciw_pkg::F_FE] = fset[sciw_pkg::F_FE] | RX_FRAMING_I;
    fset[sciw_pkg::F_PF] = fset[sciw_pkg::F_PF] | RX_PARITY_I;

    // set after clear, so a same-cycle event is never lost
    nxt.flags = (q.flags & ~fclr) | fset;
    nxt.flags[sciw_pkg::F_TRANSMIT_EMPTY_FLAG] = TX_BUF_FREE_I;
    nxt.flags[sciw_pkg::F_TC] = TX_IDLE_I;

    nxt.irq_tx = |(nxt.flags & nxt.ien & sciw_pkg::TX_GRP);
    nxt.irq_rx = |(nxt.flags & nxt.ien & sciw_pkg::RX_GRP);
    nxt.irq_err = |(nxt.flags & nxt.ien & sciw_pkg::ERR_GRP);
    nxt.irq = nxt.irq_tx | nxt.irq_rx | nxt.irq_err;
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      q <= '0;
    end else begin
      q <= nxt;
    end
  end

  assign S_AXI_AWREADY_O = q.awready;
  assign S_AXI_WREADY_O = q.wready;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_ARREADY_O = q.arready;
  assign S_AXI_RDATA_O = q.rdata;
  assign S_AXI_RRESP_O = q.rresp;
  assign S_AXI_RVALID_O = q.rvalid;
  assign RX_LEN9_O = q.ctrl[sciw_pkg::LEN9_BIT];
  assign RX_ASLEEP_O = q.ctrl[sciw_pkg::ASLEEP_BIT];
  assign IRQ_TX_O = q.irq_tx;
  assign IRQ_RX_O = q.irq_rx;
  assign IRQ_ERR_O = q.irq_err;
  assign IRQ_O = q.irq;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  idle_wake_a: assert property (
    idle_pulse && q.ctrl[sciw_pkg::ASLEEP_BIT] && !q.ctrl[sciw_pkg::WAKE_BIT]
    |=> !RX_ASLEEP_O)
    else $error("idle period did not wake the receiver");

  idle_quiet_a: assert property (
    $rose(q.flags[sciw_pkg::F_IDLE])
    |-> $past(!q.ctrl[sciw_pkg::ASLEEP_BIT] || q.ctrl[sciw_pkg::IDLE_ON_WAKEUP_ENABLE_BIT]))
    else $error("waking idle raised the idle flag");

  idle_always_a: assert property (
    idle_pulse && q.ctrl[sciw_pkg::IDLE_ON_WAKEUP_ENABLE_BIT] |=> q.flags[sciw_pkg::F_IDLE])
    else $error("idle with idle_on_wakeup_enable set did not flag");

  addr_wake_a: assert property (
    RX_MSB_VALID_I && RX_MSB_I && q.ctrl[sciw_pkg::WAKE_BIT] |=> !RX_ASLEEP_O)
    else $error("address mark did not wake the receiver");

  char_keep_a: assert property (
    RX_CHAR_DONE_I && !RX_ASLEEP_O && !q.flags[sciw_pkg::F_RECEIVE_FULL_FLAG]
    |=> q.flags[sciw_pkg::F_RECEIVE_FULL_FLAG] && q.data == $past(RX_CHAR_I))
    else $error("received character not kept");

  sleep_drop_a: assert property (
    RX_CHAR_DONE_I && RX_ASLEEP_O && !q.flags[sciw_pkg::F_RECEIVE_FULL_FLAG]
    |=> !q.flags[sciw_pkg::F_RECEIVE_FULL_FLAG] && $stable(q.data))
    else $error("sleeping receiver stored a character");

  edge_poll_a: assert property (
    RX_EDGE_I |=> q.flags[sciw_pkg::F_EDGE])
    else $error("edge flag not set regardless of enable");

  tx_req_a: assert property (
    TX_BUF_FREE_I && q.ien[sciw_pkg::F_TRANSMIT_EMPTY_FLAG] && $stable(q.ien) |=> IRQ_TX_O)
    else $error("transmit empty request dropped");

  tc_req_a: assert property (
    q.flags[sciw_pkg::F_TC] && q.ien[sciw_pkg::F_TC] |-> IRQ_TX_O)
    else $error("transmit complete request missing");

  err_grp_a: assert property (
    IRQ_ERR_O == |(q.flags & q.ien & sciw_pkg::ERR_GRP))
    else $error("error group request mismatch");

  idle_wake_c: cover property (idle_pulse && RX_ASLEEP_O ##1 !RX_ASLEEP_O);
  addr_wake_c: cover property (RX_MSB_VALID_I && RX_MSB_I && RX_ASLEEP_O ##[1:20] RX_CHAR_DONE_I);
  write_resp_c: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
endmodule

// ===== test/sciw_node_model.sv
`timescale 1ns/1ps
module sciw_node_model (
  // clock and frame size
  input wire logic clk_i,
  input wire logic len9_i,
  // line level, top data bit and received character
  output logic line_o,
  output logic msb_o,
  output logic [8:0] char_o,
  // tick, start, stop, msb, char, edge, break, noise, framing, parity
  output logic [9:0] strobe_o
);
  initial begin
    line_o = 1'b1;
    msb_o = 1'b0;
    char_o = 9'h000;
    strobe_o = 10'h000;
  end
  task automatic strobe(input int k);
    @(posedge clk_i);
    strobe_o[k] <= 1'b1;
    @(posedge clk_i);
    strobe_o <= 10'h000;
  endtask
  task automatic bit_time(input logic b);
    @(posedge clk_i);
    line_o <= b;
    strobe(0);
  endtask
  // line rests at mark between frames, as the shared bus pull-up holds it
  task automatic idle(input int n);
    repeat (n) bit_time(1'b1);
  endtask
  task automatic send_char(input logic [8:0] v);
    int nb;
    nb = len9_i ? 9 : 8;
    bit_time(1'b0);
    strobe(1);
    for (int i = 0; i < nb; i++) begin
      bit_time(v[i]);
    end
    msb_o <= v[nb-1];
    strobe(3);
    bit_time(1'b1);
    strobe(2);
    char_o <= v;
    strobe(4);
    // stale values are inverted so a late sample cannot pass by luck
    msb_o <= ~v[nb-1];
    char_o <= ~v;
  endtask
endmodule

// ===== test/sciw_top_test.sv
`timescale 1ns/1ps
module sciw_top_test;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic buf_free = 1'b0, tx_idle = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hF;
  logic [31:0] wd = 32'h0, rv, rdat;
  logic awr, wrd, bv, arr, rvl, ln, msb, len9, asleep;
  logic [1:0] br, rr;
  logic [8:0] chr;
  logic [9:0] stb;
  logic [3:0] irqs;
  int error_cnt = 0, n_tests = 0;
  localparam logic [3:0] a_ctrl = sciw_pkg::CTRL_OFS;
  localparam logic [3:0] a_ien = sciw_pkg::IEN_OFS;
  localparam logic [3:0] a_stat = sciw_pkg::STAT_OFS;
  localparam logic [3:0] a_data = sciw_pkg::DATA_OFS;
  always #50 clk = ~clk;
  sciw_top dut (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rvl), .S_AXI_RREADY_I(rry), .RX_LINE_I(ln),
    .RX_BIT_TICK_I(stb[0]), .RX_START_DONE_I(stb[1]), .RX_STOP_DONE_I(stb[2]),
    .RX_MSB_VALID_I(stb[3]), .RX_MSB_I(msb), .RX_CHAR_DONE_I(stb[4]), .RX_CHAR_I(chr),
    .RX_EDGE_I(stb[5]), .RX_BREAK_I(stb[6]), .RX_NOISE_I(stb[7]), .RX_FRAMING_I(stb[8]),
    .RX_PARITY_I(stb[9]), .TX_BUF_FREE_I(buf_free), .TX_IDLE_I(tx_idle), .RX_LEN9_O(len9),
    .RX_ASLEEP_O(asleep), .IRQ_TX_O(irqs[3]), .IRQ_RX_O(irqs[2]), .IRQ_ERR_O(irqs[1]),
    .IRQ_O(irqs[0]));
  sciw_node_model node (.clk_i(clk), .len9_i(len9), .line_o(ln), .msb_o(msb), .char_o(chr),
    .strobe_o(stb));
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    results();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int n = 0; n < 40 && !b_ok; n++) begin
      @(posedge clk);
      aw_ok |= awr;
      w_ok |= wrd;
      b_ok = bv;
      if (aw_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
    end
    bry <= 1'b0;
    if (!b_ok) hang();
    check(br, sciw_pkg::RESP_OKAY);
  endtask
  // flags land two edges after their cause, so a read first lets them settle
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic ok;
    ok = 1'b0;
    repeat (2) @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      ok = rvl;
      rv = rdat;
    end
    rry <= 1'b0;
    if (!ok) hang();
    check(rv, e);
    check(rr, sciw_pkg::RESP_OKAY);
  endtask
  task automatic t_reset();
    rchk(a_ctrl, 32'h0);
    rchk(a_ien, 32'h0);
    check(irqs, 4'h0);
    // a write with no byte lanes enabled must leave the register alone
    ws <= 4'h0;
    wr(a_ctrl, 32'h1F);
    ws <= 4'hF;
    rchk(a_ctrl, 32'h0);
  endtask
  task automatic t_idle_len();
    int need;
    for (int k = 0; k < 4; k++) begin
      need = (k[1] ? 11 : 10) - (k[0] ? 0 : 1);
      wr(a_ctrl, {29'h0, k[0], k[1], 1'b0});
      wr(a_stat, 32'h3FC);
      node.send_char(9'h000);
      node.idle(need - 1);
      rchk(a_stat, 32'h4);
      node.idle(1);
      rchk(a_stat, 32'hC);
    end
  endtask
  task automatic t_wake_idle(input logic idle_on_wakeup_enable);
    wr(a_ctrl, {27'h0, 1'b1, idle_on_wakeup_enable, 3'h0});
    wr(a_stat, 32'h3FC);
    node.send_char(9'h055);
    rchk(a_stat, 32'h0);
    rchk(a_data, {23'h0, idle_on_wakeup_enable ? 9'h03C : 9'h000});
    check(asleep, 1'b1);
    node.idle(9);
    rchk(a_ctrl, {28'h0, idle_on_wakeup_enable, 3'h0});
    check(asleep, 1'b0);
    rchk(a_stat, {28'h0, idle_on_wakeup_enable, 3'h0});
    node.send_char(9'h03C);
    rchk(a_data, 32'h03C);
    rchk(a_stat, {28'h0, idle_on_wakeup_enable, 3'h4});
  endtask
  task automatic t_addr(input logic l9);
    logic [8:0] top;
    top = l9 ? 9'h100 : 9'h080;
    wr(a_ctrl, {27'h0, 1'b1, 2'h0, l9, 1'b1});
    wr(a_stat, 32'h3FC);
    node.send_char(top - 9'h001);
    rchk(a_stat, 32'h0);
    check(asleep, 1'b1);
    node.send_char(top | 9'h011);
    check(asleep, 1'b0);
    rchk(a_data, {23'h0, top | 9'h011});
    rchk(a_stat, 32'h4);
  endtask
  task automatic t_tx();
    // receive_full is still pending from the address test
    wr(a_stat, 32'h3FC);
    buf_free <= 1'b1;
    rchk(a_stat, 32'h1);
    check(irqs, 4'h0);
    wr(a_ien, 32'h1);
    settle();
    check(irqs, 4'h9);
    buf_free <= 1'b0;
    tx_idle <= 1'b1;
    settle();
    check(irqs, 4'h0);
    wr(a_ien, 32'h2);
    settle();
    check(irqs, 4'h9);
    tx_idle <= 1'b0;
    settle();
    check(irqs, 4'h0);
  endtask
  task automatic t_sticky();
    logic [9:0] f;
    for (int k = 5; k < 10; k++) begin
      f = 10'h001 << (k < 7 ? k - 1 : k);
      node.strobe(k);
      rchk(a_stat, {22'h0, f});
      check(irqs, 4'h0);
      wr(a_ien, {22'h0, f});
      settle();
      check(irqs, k < 7 ? 4'h5 : 4'h3);
      wr(a_stat, {22'h0, f});
      rchk(a_stat, 32'h0);
      check(irqs, 4'h0);
    end
    wr(a_ien, 32'h3FC);
    node.send_char(9'h011);
    node.send_char(9'h011);
    rchk(a_stat, 32'h44);
    settle();
    check(irqs, 4'h7);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_idle_len();
    t_wake_idle(1'b0);
    t_wake_idle(1'b1);
    t_addr(1'b0);
    t_addr(1'b1);
    t_tx();
    t_sticky();
    results();
  end
endmodule
